// ### logic/mac_stats_map.vh
// register map, field positions, reset values and number of the mac statistics counters
`ifndef MAC_STATS_MAP_VH
`define MAC_STATS_MAP_VH

// ==========================================================================
// register byte offsets
`define OFF_COUNTER_CONTROL       8'h00
`define OFF_RX_COUNTER_IRQ_STATUS 8'h04
`define OFF_TX_COUNTER_IRQ_STATUS 8'h08
`define OFF_RX_COUNTER_IRQ_MASK   8'h0c
`define OFF_TX_COUNTER_IRQ_MASK   8'h10
`define OFF_TX_SINGLE_COLL_COUNT  8'h14
`define OFF_TX_MULTI_COLL_COUNT   8'h18
`define OFF_TX_GOOD_COUNT         8'h1c
`define OFF_RX_CRC_ERR_COUNT      8'h20
`define OFF_RX_ALIGN_ERR_COUNT    8'h24
`define OFF_RX_UNICAST_COUNT      8'h28

// ==========================================================================
// word index of the first counter; the six counters follow in event order
`define CNT_FIRST_IDX 6'h05
`define NUM_COUNTERS  6

// ==========================================================================
// counter_control fields
`define BIT_CLEAR_ALL_COUNTERS 0
`define BIT_SATURATE_COUNTERS  1
`define BIT_CLEAR_ON_READ      2
`define BIT_FREEZE_COUNTERS    3
`define CTRL_RW_MASK           32'h0000_000e

// ==========================================================================
// interrupt status and mask fields
`define BIT_RX_CRC_ERR   5
`define BIT_RX_ALIGN_ERR 6
`define BIT_RX_UNICAST   17
`define BIT_TX_SINGLE    14
`define BIT_TX_MULTI     15
`define BIT_TX_GOOD      21
`define RX_MASK_RW_MASK  32'h0002_0060
`define TX_MASK_RW_MASK  32'h0020_c000

// ==========================================================================
// reset values
`define RST_COUNTER_CONTROL 32'h0000_0000
`define RST_IRQ_MASK        32'h0000_0000
`define RST_COUNT           32'h0000_0000

`endif

// ### logic/mac_statistics_counters.v
// mac statistics counters with apb register access and a masked interrupt output
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "mac_stats_map.vh"

module mac_statistics_counters #(
  parameter ADDR_W = 8,
  parameter CNT_W  = 32
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output wire [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              tx_single_coll_evt,
  input  wire              tx_multi_coll_evt,
  input  wire              tx_good_evt,
  input  wire              rx_crc_err_evt,
  input  wire              rx_align_err_evt,
  input  wire              rx_unicast_evt,
  output wire              irq
);

  // ==========================================================================
  // apb handshake
  // zero wait states: read data is sampled at the setup edge, effects land at
  // the access edge, so pready and prdata both come straight from flops
  reg  [31:0] prdata_reg;
  reg  [31:0] prdata_next;
  reg         pready_reg;
  reg         pslverr_reg;
  reg         pslverr_next;
  reg  [31:0] control_reg;
  reg  [31:0] control_next;
  reg  [31:0] rx_mask_reg;
  reg  [31:0] rx_mask_next;
  reg  [31:0] tx_mask_reg;
  reg  [31:0] tx_mask_next;
  reg         irq_reg;

  wire        setup_phase;
  wire        access_done;
  wire        wr_done;
  wire        rd_done;
  wire [5:0]  word_idx;
  wire [7:0]  byte_addr;
  wire [31:0] lane_mask;
  wire        clear_all;
  wire        saturate;
  wire        clear_on_read;
  wire        freeze;
  wire [5:0]  evt;
  wire [5:0]  flag;
  wire [CNT_W*6-1:0] cnt_bus;
  wire [31:0] rx_status;
  wire [31:0] tx_status;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_reg;
  assign wr_done     = access_done & pwrite;
  assign rd_done     = access_done & ~pwrite;
  assign byte_addr   = paddr[7:0];
  assign word_idx    = byte_addr[7:2];
  assign lane_mask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  assign clear_all     = control_reg[`BIT_CLEAR_ALL_COUNTERS];
  assign saturate      = control_reg[`BIT_SATURATE_COUNTERS];
  assign clear_on_read = control_reg[`BIT_CLEAR_ON_READ];
  assign freeze        = control_reg[`BIT_FREEZE_COUNTERS];

  // event order fixes each counter's word index and its flag position
  assign evt = {rx_unicast_evt, rx_align_err_evt, rx_crc_err_evt,
                tx_good_evt, tx_multi_coll_evt, tx_single_coll_evt};

  // ==========================================================================
  // statistics counters
  genvar i;
  generate
    for (i = 0; i < `NUM_COUNTERS; i = i + 1) begin : g_cnt
      localparam [5:0] MY_IDX = `CNT_FIRST_IDX + i;
      reg  [CNT_W-1:0] cnt_reg;
      reg  [CNT_W-1:0] cnt_next;
      reg              flag_reg;
      wire             rd_hit;
      wire             inc;
      wire [CNT_W-1:0] base;
      wire [CNT_W-1:0] plus1;
      wire             at_max;
      wire             hit;

      assign rd_hit = rd_done & (word_idx == MY_IDX);
      assign inc    = evt[i] & ~freeze & ~clear_all;
      // taking off only what software saw keeps an increment that landed
      // between the setup and access edges
      assign base   = (rd_hit & clear_on_read) ? cnt_reg - prdata_reg[CNT_W-1:0]
                                               : cnt_reg;
      assign plus1  = base + {{(CNT_W-1){1'b0}}, 1'b1};
      assign at_max = &base;
      assign hit    = inc & ((plus1 == {1'b1, {(CNT_W-1){1'b0}}})
                    | (plus1 == {CNT_W{1'b1}})
                    | (at_max & saturate));

      always @* begin
        cnt_next = base;
        if (clear_all) begin
          cnt_next = {CNT_W{1'b0}};
        end else if (inc) begin
          if (at_max) begin
            cnt_next = saturate ? base : {CNT_W{1'b0}};
          end else begin
            cnt_next = plus1;
          end
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_reg  <= {CNT_W{1'b0}};
          flag_reg <= 1'b0;
        end else begin
          cnt_reg  <= cnt_next;
          flag_reg <= hit | (flag_reg & ~rd_hit);
        end
      end

      assign cnt_bus[i*CNT_W +: CNT_W] = cnt_reg;
      assign flag[i] = flag_reg;
    end
  endgenerate

  // ==========================================================================
  // interrupt status views
  assign rx_status = {14'h0000, flag[5], 10'h000, flag[4], flag[3], 5'h00};
  assign tx_status = {10'h000, flag[2], 5'h00, flag[1], flag[0], 14'h0000};

  // ==========================================================================
  // read decode, sampled in the setup cycle
  always @* begin
    prdata_next  = 32'h0000_0000;
    pslverr_next = 1'b0;
    if (byte_addr == `OFF_COUNTER_CONTROL) begin
      prdata_next = control_reg;
    end else if (byte_addr == `OFF_RX_COUNTER_IRQ_STATUS) begin
      prdata_next = rx_status;
    end else if (byte_addr == `OFF_TX_COUNTER_IRQ_STATUS) begin
      prdata_next = tx_status;
    end else if (byte_addr == `OFF_RX_COUNTER_IRQ_MASK) begin
      prdata_next = rx_mask_reg;
    end else if (byte_addr == `OFF_TX_COUNTER_IRQ_MASK) begin
      prdata_next = tx_mask_reg;
    end else if (byte_addr == `OFF_TX_SINGLE_COLL_COUNT) begin
      prdata_next[CNT_W-1:0] = cnt_bus[0*CNT_W +: CNT_W];
    end else if (byte_addr == `OFF_TX_MULTI_COLL_COUNT) begin
      prdata_next[CNT_W-1:0] = cnt_bus[1*CNT_W +: CNT_W];
    end else if (byte_addr == `OFF_TX_GOOD_COUNT) begin
      prdata_next[CNT_W-1:0] = cnt_bus[2*CNT_W +: CNT_W];
    end else if (byte_addr == `OFF_RX_CRC_ERR_COUNT) begin
      prdata_next[CNT_W-1:0] = cnt_bus[3*CNT_W +: CNT_W];
    end else if (byte_addr == `OFF_RX_ALIGN_ERR_COUNT) begin
      prdata_next[CNT_W-1:0] = cnt_bus[4*CNT_W +: CNT_W];
    end else if (byte_addr == `OFF_RX_UNICAST_COUNT) begin
      prdata_next[CNT_W-1:0] = cnt_bus[5*CNT_W +: CNT_W];
    end else begin
      pslverr_next = 1'b1;
    end
    if (pwrite) begin
      prdata_next = 32'h0000_0000;
    end
  end

  // ==========================================================================
  // register writes, taken at the access edge
  // writes to status and counter words are ignored without error
  always @* begin
    control_next = control_reg & ~(32'h0000_0001 << `BIT_CLEAR_ALL_COUNTERS);
    rx_mask_next = rx_mask_reg;
    tx_mask_next = tx_mask_reg;
    if (wr_done) begin
      if (byte_addr == `OFF_COUNTER_CONTROL) begin
        control_next = ((control_reg & ~lane_mask) | (pwdata & lane_mask))
                       & `CTRL_RW_MASK;
        control_next[`BIT_CLEAR_ALL_COUNTERS] = pstrb[0]
                                                & pwdata[`BIT_CLEAR_ALL_COUNTERS];
      end else if (byte_addr == `OFF_RX_COUNTER_IRQ_MASK) begin
        rx_mask_next = ((rx_mask_reg & ~lane_mask) | (pwdata & lane_mask))
                       & `RX_MASK_RW_MASK;
      end else if (byte_addr == `OFF_TX_COUNTER_IRQ_MASK) begin
        tx_mask_next = ((tx_mask_reg & ~lane_mask) | (pwdata & lane_mask))
                       & `TX_MASK_RW_MASK;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      control_reg <= `RST_COUNTER_CONTROL;
      rx_mask_reg <= `RST_IRQ_MASK;
      tx_mask_reg <= `RST_IRQ_MASK;
      irq_reg     <= 1'b0;
    end else begin
      pready_reg  <= setup_phase;
      if (setup_phase) begin
        prdata_reg  <= prdata_next;
        pslverr_reg <= pslverr_next;
      end else if (access_done) begin
        pslverr_reg <= 1'b0;
      end
      control_reg <= control_next;
      rx_mask_reg <= rx_mask_next;
      tx_mask_reg <= tx_mask_next;
      irq_reg     <= |(rx_status & ~rx_mask_reg)
                   | (|(tx_status & ~tx_mask_reg));
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;

endmodule

// ### dv/mac_stats_props.sv
// checker of bus timing and interrupt behaviour of the statistics counters
`timescale 1ns/1ns
`include "mac_stats_map.vh"
module mac_stats_props #(
  parameter ADDR_W = 8
) (
  input wire              pclk,
  input wire              presetn,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       pwdata,
  input wire [3:0]        pstrb,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              pslverr,
  input wire              tx_single_coll_evt,
  input wire              tx_multi_coll_evt,
  input wire              tx_good_evt,
  input wire              rx_crc_err_evt,
  input wire              rx_align_err_evt,
  input wire              rx_unicast_evt,
  input wire              irq
);
  // ==========================================================================
  // helper state
  // mask copy ignores pstrb: only full-word mask writes are tracked
  reg  [31:0] rx_mask_reg;
  reg  [31:0] tx_mask_reg;
  wire        acc = psel && penable && pready;
  wire        mwr = acc && pwrite && (paddr == 8'h0c || paddr == 8'h10);
  wire        cnt_rd = acc && !pwrite && paddr >= 8'h14 && paddr <= 8'h28;
  wire        any_evt = tx_single_coll_evt || tx_multi_coll_evt || tx_good_evt ||
                        rx_crc_err_evt || rx_align_err_evt || rx_unicast_evt;
  wire        all_msk = rx_mask_reg == `RX_MASK_RW_MASK && tx_mask_reg == `TX_MASK_RW_MASK;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_mask_reg <= 32'h0;
      tx_mask_reg <= 32'h0;
    end else if (mwr && paddr == 8'h0c) begin
      rx_mask_reg <= pwdata & `RX_MASK_RW_MASK;
    end else if (mwr) begin
      tx_mask_reg <= pwdata & `TX_MASK_RW_MASK;
    end
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_setup_then_ready: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_err: assert property (pready |-> pslverr == (paddr > 8'h28 || paddr[1:0] != 2'h0))
    else $error("pslverr wrong for address");
  a_rx_rsvd_zero: assert property (acc && !pwrite && paddr == 8'h04 |->
    (prdata & ~`RX_MASK_RW_MASK) == 32'h0) else $error("rx status reserved bit set");
  a_tx_rsvd_zero: assert property (acc && !pwrite && paddr == 8'h08 |->
    (prdata & ~`TX_MASK_RW_MASK) == 32'h0) else $error("tx status reserved bit set");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(cnt_rd, 2) || $past(mwr, 2))
    else $error("irq dropped without counter read");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(any_evt, 2) || $past(mwr, 2))
    else $error("irq rose without cause");
  a_irq_all_masked: assert property (all_msk && $past(all_msk) |-> !irq)
    else $error("irq high while all masked");
  c_irq_up: cover property ($rose(irq));
  c_unmapped: cover property (pready && pslverr);
  c_count_read: cover property (cnt_rd && prdata != 32'h0);
endmodule

bind mac_statistics_counters mac_stats_props #(.ADDR_W(ADDR_W)) props_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_single_coll_evt(tx_single_coll_evt),
  .tx_multi_coll_evt(tx_multi_coll_evt), .tx_good_evt(tx_good_evt),
  .rx_crc_err_evt(rx_crc_err_evt), .rx_align_err_evt(rx_align_err_evt),
  .rx_unicast_evt(rx_unicast_evt), .irq(irq));

// ### dv/tb.sv
// self-checking bench of the mac statistics counters
`timescale 1ns/1ns
`include "mac_stats_map.vh"
module tb;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg  [5:0]  ev = 6'h00;
  reg  [31:0] lfsr = 32'h3a;
  reg  [31:0] rd_v;
  reg         err_v;
  reg  [31:0] cnt_e [0:5];
  reg  [7:0]  ca;
  reg  [7:0]  sa;
  reg  [31:0] fb;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        irq;
  integer     error_cnt = 0;
  integer     checks = 0;
  integer     cyc = 0;
  integer     i;
  integer     k;
  always #4 pclk = ~pclk;
  // 8-bit counters so that half and full range are reached in a short run
  mac_statistics_counters #(.ADDR_W(8), .CNT_W(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_single_coll_evt(ev[0]), .tx_multi_coll_evt(ev[1]),
    .tx_good_evt(ev[2]), .rx_crc_err_evt(ev[3]), .rx_align_err_evt(ev[4]),
    .rx_unicast_evt(ev[5]), .irq(irq));
  // ==========================================================================
  // helpers
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [31:0] fbit(input integer n);
    fbit = 32'h1 << (n == 0 ? 14 : n == 1 ? 15 : n == 2 ? 21 : n == 3 ? 5 : n == 4 ? 6 : 17);
  endfunction
  task close_out;
    begin
      if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // request held until the rising edge that samples pready high; one idle cycle between calls
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task fire(input [5:0] m, input integer n);
    begin
      @(posedge pclk);
      ev <= m;
      repeat (n) @(posedge pclk);
      ev <= 6'h00;
    end
  endtask
  // whole run needs about 2100 cycles
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k <= 44; k = k + 4) begin
      bus(1'b0, k[7:0], 32'h0);
      chk(rd_v, 32'h0);
      chk({31'h0, err_v}, {31'h0, k == 44});
    end
    for (k = 0; k < 4; k = k + 1) begin
      lfsr = nxt(lfsr);
      bus(1'b1, 8'h0c + 8'h04 * k[7:0], lfsr);
      bus(1'b0, 8'h0c + 8'h04 * k[7:0], 32'h0);
      chk(rd_v, k < 2 ? lfsr & (k[0] ? `TX_MASK_RW_MASK : `RX_MASK_RW_MASK) : 32'h0);
    end
    for (i = 0; i < 6; i = i + 1) begin
      lfsr = nxt(lfsr);
      cnt_e[i] = (lfsr & 32'hf) + 32'h1;
      ca = 8'h14 + 8'h04 * i[7:0];
      fire(6'h01 << i, cnt_e[i]);
      bus(1'b0, ca, 32'h0);
      chk(rd_v, cnt_e[i]);
    end
    bus(1'b1, 8'h00, 32'h8);
    fire(6'h3f, 5);
    for (i = 0; i < 6; i = i + 1) begin
      bus(1'b0, 8'h14 + 8'h04 * i[7:0], 32'h0);
      chk(rd_v, cnt_e[i]);
    end
    bus(1'b1, 8'h00, 32'hc);
    bus(1'b0, 8'h14, 32'h0);
    chk(rd_v, cnt_e[0]);
    bus(1'b0, 8'h14, 32'h0);
    chk(rd_v, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd_v, 32'h0);
    bus(1'b0, 8'h28, 32'h0);
    chk(rd_v, 32'h0);
    for (i = 0; i < 6; i = i + 1) begin
      ca = 8'h14 + 8'h04 * i[7:0];
      sa = i < 3 ? 8'h08 : 8'h04;
      fb = fbit(i);
      fire(6'h01 << i, 127);
      bus(1'b0, sa, 32'h0);
      chk(rd_v, 32'h0);
      fire(6'h01 << i, 1);
      bus(1'b0, sa, 32'h0);
      chk(rd_v, fb);
      bus(1'b0, sa, 32'h0);
      chk(rd_v, fb);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, sa + 8'h08, fb);
      @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, 8'h0c, 32'hffff_ffff);
      bus(1'b1, 8'h10, 32'hffff_ffff);
      bus(1'b1, 8'h0c, 32'h0);
      bus(1'b1, 8'h10, 32'h0);
      bus(1'b0, ca, 32'h0);
      chk(rd_v, 32'h80);
      bus(1'b0, sa, 32'h0);
      chk(rd_v, 32'h0);
      fire(6'h01 << i, 127);
      bus(1'b0, sa, 32'h0);
      chk(rd_v, fb);
      bus(1'b1, 8'h00, 32'h2);
      bus(1'b0, ca, 32'h0);
      fire(6'h01 << i, 1);
      bus(1'b0, sa, 32'h0);
      chk(rd_v, fb);
      bus(1'b0, ca, 32'h0);
      chk(rd_v, 32'hff);
      bus(1'b1, 8'h00, 32'h0);
      fire(6'h01 << i, 1);
      bus(1'b0, ca, 32'h0);
      chk(rd_v, 32'h0);
      bus(1'b0, sa, 32'h0);
      chk(rd_v, 32'h0);
    end
    close_out;
  end
endmodule
